// File: logic/trig_ctrl_pkg.sv
/*
 package of the trigger control block: register offsets, field layout,
 reset values, timing constants and the acquisition state type.
 assumes a 25 MHz clock and a one-cycle read latency register port.
*/
package trig_ctrl_pkg;
    // ****************************************
    // clock and time base
    // ****************************************
    localparam int CLK_HZ = 25_000_000;
    localparam int TIME_BASE_US = 1;
    localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TIME_BASE_US;
    localparam int TICK_W = 5;
    localparam logic [TICK_W-1:0] TICK_LAST = 5'(TICK_CYCLES - 1);

    // ****************************************
    // register map
    // ****************************************
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_EXPOSURE = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_PERIOD = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_READOUT = 4'hc;
    localparam int TIME_W = 24;

    // ctrl field positions
    localparam int BIT_ACQ_MODE = 0;
    localparam int BIT_FRM_MODE = 1;
    localparam int BIT_PERIOD_EN = 2;
    localparam int BIT_SRC_LINE = 3;
    localparam int BIT_ACQ_EN = 4;
    localparam int CTRL_W = 5;
    // status field positions, read from the ctrl offset
    localparam int ST_POS = 8;
    localparam int ST_W = 2;
    localparam int BIT_LINE_LVL = 10;
    localparam int FCNT_POS = 16;
    localparam int FCNT_W = 16;

    // reset values
    localparam logic [CTRL_W-1:0] CTRL_RST = 5'h00;
    localparam logic [TIME_W-1:0] EXPOSURE_RST = 24'h0003e8;
    localparam logic [TIME_W-1:0] PERIOD_RST = 24'h002710;
    localparam logic [TIME_W-1:0] READOUT_RST = 24'h0003e8;
    localparam logic [TIME_W-1:0] TIME_ONE = 24'h000001;
    localparam logic [TIME_W-1:0] TIME_ZERO = 24'h000000;

    // acquisition states, gray along idle -> wait -> expose -> readout
    typedef enum logic [ST_W-1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT_FRAME = 2'b01,
        ST_EXPOSE = 2'b11,
        ST_READOUT = 2'b10
    } acq_state_t;
endpackage

// File: logic/trig_ctrl.sv
/*
 acquisition trigger control: decides when frames are exposed, in free run
 or on rising edges of the general-purpose line used as input line one.
 assumes all inputs synchronous to clk except line_in, which is synchronised here.
*/
// Local design decisions: strobed register access and the address map.
`timescale 1ns/100ps
module trig_ctrl
    import trig_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [DATA_W-1:0] rdata,
    input wire logic line_in,
    output logic line_out,
    output logic line_oe_n,
    output logic exposing,
    output logic frame_start,
    output logic readout_active,
    output logic trig_overrun
);
    // ****************************************
    // register port
    // ****************************************
    logic [CTRL_W-1:0] ctrl_reg, ctrl_next;
    logic [TIME_W-1:0] exposure_reg, exposure_next;
    logic [TIME_W-1:0] period_reg, period_next;
    logic [TIME_W-1:0] readout_reg, readout_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    acq_state_t state_reg, state_next;
    logic [FCNT_W-1:0] fcnt_reg, fcnt_next;
    logic sync1_reg, sync2_reg, line_prev_reg;

    function automatic logic [TIME_W-1:0] clamp_time(input logic [DATA_W-1:0] v);
        clamp_time = (v[TIME_W-1:0] == TIME_ZERO) ? TIME_ONE : v[TIME_W-1:0];
    endfunction

    function automatic logic [TIME_W-1:0] count_down(input logic [TIME_W-1:0] t);
        count_down = t - TIME_ONE;
    endfunction

    always_comb
    begin
        ctrl_next = ctrl_reg;
        exposure_next = exposure_reg;
        period_next = period_reg;
        readout_next = readout_reg;
        rdata_next = '0;
        if (wr)
        begin
            case (addr)
                OFS_CTRL: ctrl_next = wdata[CTRL_W-1:0];
                OFS_EXPOSURE: exposure_next = clamp_time(wdata);
                OFS_PERIOD: period_next = clamp_time(wdata);
                OFS_READOUT: readout_next = clamp_time(wdata);
                default: ;
            endcase
        end
        if (rd)
        begin
            case (addr)
                OFS_CTRL:
                begin
                    rdata_next[CTRL_W-1:0] = ctrl_reg;
                    rdata_next[ST_POS +: ST_W] = state_reg;
                    rdata_next[BIT_LINE_LVL] = sync2_reg;
                    rdata_next[FCNT_POS +: FCNT_W] = fcnt_reg;
                end
                OFS_EXPOSURE: rdata_next[TIME_W-1:0] = exposure_reg;
                OFS_PERIOD: rdata_next[TIME_W-1:0] = period_reg;
                OFS_READOUT: rdata_next[TIME_W-1:0] = readout_reg;
                default: rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            ctrl_reg <= CTRL_RST;
            exposure_reg <= EXPOSURE_RST;
            period_reg <= PERIOD_RST;
            readout_reg <= READOUT_RST;
            rdata_reg <= '0;
        end
        else
        begin
            ctrl_reg <= ctrl_next;
            exposure_reg <= exposure_next;
            period_reg <= period_next;
            readout_reg <= readout_next;
            rdata_reg <= rdata_next;
        end
    end

    assign rdata = rdata_reg;

    // ****************************************
    // line input and edge detect
    // ****************************************
    logic src_line, line_rise;
    assign src_line = ctrl_reg[BIT_SRC_LINE];
    assign line_out = 1'b0;
    assign line_oe_n = 1'b1;

    logic sync1_next, sync2_next, line_prev_next;
    always_comb
    begin
        sync1_next = line_in;
        sync2_next = sync1_reg;
        line_prev_next = sync2_reg;
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            line_prev_reg <= 1'b0;
        end
        else
        begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            line_prev_reg <= line_prev_next;
        end
    end

    assign line_rise = src_line && sync2_reg && !line_prev_reg;

    // ****************************************
    // microsecond tick
    // ****************************************
    logic [TICK_W-1:0] tick_reg, tick_next;
    logic tick;
    assign tick = (tick_reg == TICK_LAST);

    always_comb
    begin
        tick_next = tick ? '0 : tick_reg + 5'(1);
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
            tick_reg <= '0;
        else
            tick_reg <= tick_next;
    end

    // ****************************************
    // acquisition sequencer
    // ****************************************
    logic [TIME_W-1:0] time_reg, time_next;   // us left in exposure or readout
    logic [TIME_W-1:0] per_reg, per_next;     // us since last frame start
    logic overrun_reg, overrun_next;
    logic fs_reg, fs_next;
    logic acq_en, acq_mode, frm_mode, per_en, internal_go, trig;
    logic per_full;

    assign acq_en = ctrl_reg[BIT_ACQ_EN];
    assign acq_mode = ctrl_reg[BIT_ACQ_MODE];
    assign frm_mode = ctrl_reg[BIT_FRM_MODE];
    assign per_en = ctrl_reg[BIT_PERIOD_EN];
    assign per_full = (per_reg == {TIME_W{1'b1}});
    // period gate: with period enable set, free run waits until the period has passed since the last start
    assign internal_go = !per_en || (per_reg >= period_reg);
    assign trig = frm_mode ? line_rise : internal_go;

    always_comb
    begin
        state_next = state_reg;
        time_next = time_reg;
        per_next = per_reg;
        fcnt_next = fcnt_reg;
        overrun_next = 1'b0;
        fs_next = 1'b0;
        if (tick && !per_full)
            per_next = per_reg + TIME_ONE;
        case (state_reg)
            ST_IDLE:
            begin
                // acquisition start mode on keeps the sequencer in idle
                if (acq_en && !acq_mode)
                    state_next = ST_WAIT_FRAME;
            end
            ST_WAIT_FRAME:
            begin
                if (!acq_en || acq_mode)
                    state_next = ST_IDLE;
                else if (trig)
                begin
                    state_next = ST_EXPOSE;
                    time_next = exposure_reg;
                    per_next = TIME_ZERO;
                    fs_next = 1'b1;
                    fcnt_next = fcnt_reg + 16'(1);
                end
            end
            ST_EXPOSE:
            begin
                if (line_rise)
                    overrun_next = 1'b1;
                if (tick)
                begin
                    if (time_reg == TIME_ZERO)
                    begin
                        state_next = ST_READOUT;
                        time_next = readout_reg;
                    end
                    else
                        time_next = count_down(time_reg);
                end
            end
            ST_READOUT:
            begin
                if (line_rise)
                    overrun_next = 1'b1;
                if (tick)
                begin
                    if (time_reg == TIME_ONE)
                        state_next = ST_WAIT_FRAME;
                    else
                        time_next = count_down(time_reg);
                end
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            state_reg <= ST_IDLE;
            time_reg <= TIME_ZERO;
            per_reg <= TIME_ZERO;
            fcnt_reg <= '0;
            overrun_reg <= 1'b0;
            fs_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            time_reg <= time_next;
            per_reg <= per_next;
            fcnt_reg <= fcnt_next;
            overrun_reg <= overrun_next;
            fs_reg <= fs_next;
        end
    end

    assign frame_start = fs_reg;
    assign trig_overrun = overrun_reg;

    // ****************************************
    // status outputs
    // ****************************************
    logic exposing_reg, exposing_next;
    logic readout_active_reg, readout_active_next;

    always_comb
    begin
        // registered copies of the next-state decode
        exposing_next = (state_next == ST_EXPOSE);
        readout_active_next = (state_next == ST_READOUT);
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            exposing_reg <= 1'b0;
            readout_active_reg <= 1'b0;
        end
        else
        begin
            exposing_reg <= exposing_next;
            readout_active_reg <= readout_active_next;
        end
    end

    assign exposing = exposing_reg;
    assign readout_active = readout_active_reg;
endmodule

// File: tb/trig_ctrl_properties.sv
/*
 port assertions of trig_ctrl.
 assumes a bind from the bench top.
*/
`timescale 1ns/100ps
module trig_ctrl_properties
    import trig_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic line_in,
    input wire logic line_oe_n,
    input wire logic exposing,
    input wire logic frame_start,
    input wire logic readout_active,
    input wire logic trig_overrun
);
    // ****************
    // mode copy, line edge age
    // ****************
    logic [CTRL_W-1:0] mode_reg, mode_next;
    logic [3:0] age_reg, age_next;
    logic line_reg, line_next;
    always_comb
    begin
        mode_next = mode_reg;
        if (wr && addr == OFS_CTRL)
            mode_next = wdata[CTRL_W-1:0];
        line_next = line_in;
        age_next = (age_reg == 4'hf) ? age_reg : age_reg + 4'h1;
        if (line_in && !line_reg)
            age_next = 4'h0;
        if (!nrst)
        begin
            mode_next = CTRL_RST;
            age_next = 4'hf;
        end
    end
    always_ff @(posedge clk)
    begin
        mode_reg <= mode_next;
        age_reg <= age_next;
        line_reg <= line_next;
    end
    // ****************
    // properties
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_line_input: assert property (line_oe_n)
        else $error("line driven");
    chk_start_exposes: assert property (frame_start |-> exposing)
        else $error("start without exposure");
    chk_start_single: assert property (frame_start |=> !frame_start)
        else $error("start longer than a cycle");
    chk_expose_hold: assert property (frame_start |=> exposing [*8])
        else $error("exposure cut short");
    chk_expose_readout: assert property ($fell(exposing) |-> readout_active)
        else $error("exposure not followed by readout");
    chk_overrun_drop: assert property (trig_overrun
        |-> !frame_start && age_reg inside {[1:6]})
        else $error("overrun without a line rise or with a start");
    chk_line_edge: assert property (frame_start && mode_reg[BIT_FRM_MODE]
        |-> age_reg inside {[1:6]})
        else $error("triggered start without line rise");
    chk_free_next: assert property ($fell(readout_active) && mode_reg == 5'h10
        |-> ##[0:4] frame_start)
        else $error("free run did not restart");
    cover property (frame_start && mode_reg[BIT_FRM_MODE]);
    cover property (trig_overrun);
    cover property ($fell(readout_active) && mode_reg == 5'h10);
endmodule

// File: tb/line_driver.sv
/*
 sensing device model: one rising edge on the line per fire request.
 assumes fire is a one-cycle pulse from the bench.
*/
`timescale 1ns/100ps
module line_driver
(
    input wire logic clk,
    input wire logic fire,
    output logic line_in
);
    logic [2:0] cnt = 3'h0;
    initial line_in = 1'b0;
    always @(posedge clk)
    begin
        if (fire && cnt == 3'h0)
        begin
            line_in <= 1'b1;
            cnt <= 3'h4;
        end
        else if (cnt != 3'h0)
        begin
            cnt <= cnt - 3'h1;
            line_in <= (cnt != 3'h1);
        end
    end
endmodule

// File: tb/trig_ctrl_tb.sv
/*
 bench of trig_ctrl: registers, free run, period, line triggers.
 assumes line_driver and trig_ctrl_properties.
*/
`timescale 1ns/100ps
module trig_ctrl_tb
    import trig_ctrl_pkg::*;
;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [ADDR_W-1:0] addr = 4'h0;
    logic [DATA_W-1:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic fire = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic line_in, line_out, line_oe_n, exposing, frame_start, readout_active, trig_overrun;
    int err_count = 0;
    int checked = 0;
    int fs_n = 0;
    int ov_n = 0;
    int g, n0;
    trig_ctrl i_trig_ctrl (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .line_in(line_in), .line_out(line_out),
        .line_oe_n(line_oe_n), .exposing(exposing), .frame_start(frame_start),
        .readout_active(readout_active), .trig_overrun(trig_overrun));
    line_driver i_line_driver (.clk(clk), .fire(fire), .line_in(line_in));
    initial forever #20 clk = ~clk;
    always @(posedge clk)
    begin
        fs_n += (frame_start === 1'b1);
        ov_n += (trig_overrun === 1'b1);
    end
    // ****************
    // tasks
    // ****************
    task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checked++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdata, exp);
    endtask
    task automatic wait_fs(output int n);
        n = 0;
        do
        begin
            @(posedge clk);
            #1 n++;
        end
        while (frame_start !== 1'b1 && n < 2000);
    endtask
    task automatic gap_in(input int lo, input int hi);
        repeat (3) wait_fs(g);
        check(32'(g >= lo && g <= hi), 32'h1);
    endtask
    task automatic pulse;
        @(posedge clk);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ****************
    // tests
    // ****************
    initial
    begin
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(OFS_EXPOSURE, 32'h3e8);
        rd_reg(OFS_PERIOD, 32'h2710);
        rd_reg(OFS_READOUT, 32'h3e8);
        wr_reg(4'h2, 32'hffff_ffff);
        rd_reg(4'h2, 32'h0);
        wr_reg(OFS_EXPOSURE, 32'h0);
        rd_reg(OFS_EXPOSURE, 32'h1);
        wr_reg(OFS_EXPOSURE, 32'h2);
        wr_reg(OFS_READOUT, 32'h2);
        wr_reg(OFS_CTRL, 32'h10);
        gap_in(100, 155);
        wr_reg(OFS_PERIOD, 32'h8);
        wr_reg(OFS_CTRL, 32'h14);
        gap_in(200, 230);
        wr_reg(OFS_PERIOD, 32'h1);
        wr_reg(OFS_EXPOSURE, 32'h8);
        gap_in(250, 305);
        wr_reg(OFS_EXPOSURE, 32'h2);
        wr_reg(OFS_CTRL, 32'h11);
        repeat (400) @(posedge clk);
        n0 = fs_n;
        repeat (300) @(posedge clk);
        check(32'(fs_n), 32'(n0));
        wr_reg(OFS_CTRL, 32'h1a);
        repeat (300) @(posedge clk);
        check(32'(fs_n), 32'(n0));
        rd_reg(OFS_CTRL, (32'(fs_n) << 16) | 32'h11a);
        pulse();
        wait_fs(g);
        check(32'(g <= 8), 32'h1);
        check(32'(exposing), 32'h1);
        n0 = ov_n;
        repeat (6) @(posedge clk);
        pulse();
        repeat (12) @(posedge clk);
        check(32'(ov_n), 32'(n0 + 1));
        repeat (65) @(posedge clk);
        #1 check(32'(readout_active), 32'h1);
        check(32'(exposing), 32'h0);
        n0 = fs_n;
        repeat (300) @(posedge clk);
        check(32'(fs_n), 32'(n0));
        check(32'(line_oe_n), 32'h1);
        check(32'(line_out), 32'h0);
        tally_and_finish();
    end
    initial
    begin
        #800000;
        err_count++;
        tally_and_finish();
    end
endmodule
bind trig_ctrl trig_ctrl_properties i_trig_ctrl_properties (.clk(clk), .nrst(nrst),
    .addr(addr), .wdata(wdata), .wr(wr), .line_in(line_in), .line_oe_n(line_oe_n),
    .exposing(exposing), .frame_start(frame_start), .readout_active(readout_active),
    .trig_overrun(trig_overrun));
